// [design/devctl_pkg.sv]
// package: device control register map, field layout and transaction carriers
package devctl_pkg;

  // register map (0x48 is a multiple of four, so it is the byte address)
  localparam logic [7:0] DEVICE_CONTROL_OFS = 8'h48;
  localparam int ADDR_W = 8;

  // field positions
  localparam int CORR_BIT = 0;
  localparam int NONFATAL_BIT = 1;
  localparam int FATAL_BIT = 2;
  localparam int UNSUPP_BIT = 3;
  localparam int RELAX_BIT = 4;
  localparam int MPS_LO = 5;
  localparam int MPS_HI = 7;
  localparam int WIDE_TAG_BIT = 8;
  localparam int PHANTOM_BIT = 9;
  localparam int AUX_PM_BIT = 10;
  localparam int NO_SNOOP_BIT = 11;
  localparam int MAX_READ_REQ_SEL_LO = 12;
  localparam int MAX_READ_REQ_SEL_HI = 14;
  localparam int RSVD_BIT = 15;

  // reset values
  localparam logic [0:0] REPORT_EN_RST = 1'h0;
  localparam logic [0:0] RELAX_RST = 1'h1;
  localparam logic [2:0] MPS_RST = 3'h0;
  localparam logic [0:0] WIDE_TAG_RST = 1'h0;
  localparam logic [0:0] NO_SNOOP_RST = 1'h0;
  localparam logic [2:0] MAX_READ_REQ_SEL_RST = 3'h2;

  // payload size codes
  localparam logic [2:0] MPS_MAX_CODE = 3'h4;
  localparam logic [12:0] PAYLOAD_128 = 13'h0080;

  // writable bit mask of the 16-bit register (bits 9, 10, 15 fixed at zero)
  localparam logic [15:0] DEVCTL_WR_MASK = 16'h79FF;

  // fields of the device control register
  typedef struct packed {
    logic rsvd;
    logic [2:0] max_read_req_sel;
    logic no_snoop_en;
    logic aux_power_pm_en;
    logic phantom_func_en;
    logic wide_tag_en;
    logic [2:0] max_payload_sel;
    logic relaxed_order_en;
    logic unsupp_req_report_en;
    logic fatal_report_en;
    logic nonfatal_report_en;
    logic correctable_report_en;
  } device_control_t;

  // transaction attributes passing the bridge
  typedef struct packed {
    logic relaxed_order;
    logic no_snoop;
    logic [7:0] tag;
    logic [12:0] req_bytes;
  } tlp_attr_t;

  // raw error events
  typedef struct packed {
    logic correctable;
    logic nonfatal;
    logic fatal;
    logic unsupp_req;
  } err_event_t;

endpackage

// [design/attr_forward.sv]
// attribute forwarding path from the opposite side to this side
`timescale 1ns/1ps
`default_nettype none
module attr_forward (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic relaxed_order_en_i,
  // inbound transaction
  input wire logic in_valid_i,
  input wire devctl_pkg::tlp_attr_t in_attr_i,
  // outbound transaction
  output logic out_valid_o,
  output devctl_pkg::tlp_attr_t out_attr_o
);
  import devctl_pkg::*;

  // register the transaction, clearing relaxed ordering when disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_attr_o <= '0;
    end else begin
      out_valid_o <= in_valid_i;
      if (in_valid_i) begin
        out_attr_o <= in_attr_i; // tag, no snoop, size kept
        out_attr_o.relaxed_order <= in_attr_i.relaxed_order & relaxed_order_en_i;
      end
    end
  end
endmodule
`default_nettype wire

// [design/device_control_reg.sv]
// device control register with wishbone slave and its effects on traffic
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module device_control_reg (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [devctl_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // error events and gated reports
  input wire devctl_pkg::err_event_t err_event_i,
  output devctl_pkg::err_event_t err_report_o,
  // forwarded traffic, opposite side to this side
  input wire logic fwd_valid_i,
  input wire devctl_pkg::tlp_attr_t fwd_attr_i,
  output logic fwd_valid_o,
  output devctl_pkg::tlp_attr_t fwd_attr_o,
  // locally originated requests
  input wire logic orig_valid_i,
  input wire logic [12:0] orig_bytes_i,
  output logic orig_valid_o,
  output devctl_pkg::tlp_attr_t orig_attr_o,
  // control view
  output logic [12:0] payload_limit_o,
  output devctl_pkg::device_control_t device_control_o
);
  import devctl_pkg::*;

  // ---------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------
  device_control_t device_control_q;
  logic [15:0] wr_data;
  logic [15:0] wr_mask;
  logic [15:0] merged;
  logic hit;
  logic wr_en;

  // address decode on the aligned word
  assign hit = (wb_adr_i[ADDR_W-1:2] == DEVICE_CONTROL_OFS[ADDR_W-1:2]);
  // the write lands at the edge where the master samples ack high, never earlier
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & hit;

  // byte lanes 0 and 1 carry the register; fixed bits never take a write
  assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & DEVCTL_WR_MASK;
  assign wr_data = wb_dat_i[15:0];
  assign merged = (wr_data & wr_mask) | (16'(device_control_q) & ~wr_mask);

  // update the writable fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      device_control_q <= '0;
      device_control_q.correctable_report_en <= REPORT_EN_RST;
      device_control_q.nonfatal_report_en <= REPORT_EN_RST;
      device_control_q.fatal_report_en <= REPORT_EN_RST;
      device_control_q.unsupp_req_report_en <= REPORT_EN_RST;
      device_control_q.relaxed_order_en <= RELAX_RST;
      device_control_q.max_payload_sel <= MPS_RST;
      device_control_q.wide_tag_en <= WIDE_TAG_RST;
      device_control_q.no_snoop_en <= NO_SNOOP_RST;
      device_control_q.max_read_req_sel <= MAX_READ_REQ_SEL_RST;
    end else if (wr_en) begin
      device_control_q <= device_control_t'(merged);
    end
  end

  assign device_control_o = device_control_q;

  // ---------------------------------------------------------------------
  // wishbone answer: one wait state, ack dropped the cycle after
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
        // unmapped words read zero; upper half always zero
        wb_dat_o <= hit ? {16'h0000, 16'(device_control_q)} : 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------
  // error report gating
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_report_o <= '0;
    end else begin
      err_report_o.correctable <= err_event_i.correctable &
                                  device_control_q.correctable_report_en;
      err_report_o.nonfatal <= err_event_i.nonfatal &
                               device_control_q.nonfatal_report_en;
      err_report_o.fatal <= err_event_i.fatal & device_control_q.fatal_report_en;
      err_report_o.unsupp_req <= err_event_i.unsupp_req &
                                 device_control_q.unsupp_req_report_en;
    end
  end

  // ---------------------------------------------------------------------
  // payload limit decode
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      payload_limit_o <= PAYLOAD_128;
    end else if (device_control_q.max_payload_sel > MPS_MAX_CODE) begin
      payload_limit_o <= PAYLOAD_128; // reserved codes
    end else begin
      payload_limit_o <= 13'(PAYLOAD_128 << device_control_q.max_payload_sel);
    end
  end

  // ---------------------------------------------------------------------
  // forwarded traffic
  // ---------------------------------------------------------------------
  attr_forward u_fwd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .relaxed_order_en_i(device_control_q.relaxed_order_en),
    .in_valid_i(fwd_valid_i),
    .in_attr_i(fwd_attr_i),
    .out_valid_o(fwd_valid_o),
    .out_attr_o(fwd_attr_o)
  );

  // ---------------------------------------------------------------------
  // originated requests: tag zero, no snoop clear, at most 128 bytes
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      orig_valid_o <= 1'b0;
      orig_attr_o <= '0;
    end else begin
      orig_valid_o <= orig_valid_i;
      if (orig_valid_i) begin
        orig_attr_o.tag <= 8'h00;
        orig_attr_o.no_snoop <= 1'b0;
        orig_attr_o.relaxed_order <= 1'b0;
        orig_attr_o.req_bytes <= (orig_bytes_i > PAYLOAD_128) ?
                                 PAYLOAD_128 : orig_bytes_i;
      end
    end
  end

endmodule
`default_nettype wire

// [dv/devctl_props.sv]
// checker: port properties of the device control register
`timescale 1ns/1ps
`default_nettype none
module devctl_props (
  // clock, reset and bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // traffic and control view
  input wire devctl_pkg::err_event_t err_event_i,
  input wire devctl_pkg::err_event_t err_report_o,
  input wire logic fwd_valid_i,
  input wire devctl_pkg::tlp_attr_t fwd_attr_i,
  input wire logic fwd_valid_o,
  input wire devctl_pkg::tlp_attr_t fwd_attr_o,
  input wire logic orig_valid_i,
  input wire logic orig_valid_o,
  input wire devctl_pkg::tlp_attr_t orig_attr_o,
  input wire logic [12:0] payload_limit_o,
  input wire devctl_pkg::device_control_t device_control_o
);
  import devctl_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // events gated by enables, enable bit 0 maps to the struct msb
  err_event_t gate;
  assign gate = err_event_i & {device_control_o[0], device_control_o[1],
                               device_control_o[2], device_control_o[3]};
  // request strobe raised, then a single ack pulse
  sequence s_take; $rose(wb_stb_i); endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_take |=> s_pulse; endproperty
  property p_err; 1 |=> err_report_o == $past(gate); endproperty
  property p_relax; fwd_valid_i |=> fwd_valid_o && fwd_attr_o.relaxed_order ==
    $past(fwd_attr_i.relaxed_order && device_control_o.relaxed_order_en); endproperty
  property p_pass; fwd_valid_i |=> fwd_attr_o[21:0] == $past(fwd_attr_i[21:0]); endproperty
  property p_orig; orig_valid_i |=> orig_valid_o && orig_attr_o.tag == 8'h00 &&
    !orig_attr_o.no_snoop && orig_attr_o.req_bytes <= 13'h0080; endproperty
  property p_fixed; !device_control_o.phantom_func_en && !device_control_o.aux_power_pm_en
    && !device_control_o.rsvd; endproperty
  property p_mps; 1 |=> payload_limit_o == (($past(device_control_o[7:5]) > 3'h4) ?
    13'h0080 : (13'h0080 << $past(device_control_o[7:5]))); endproperty
  property p_reset; $fell(rst_i) |-> device_control_o == 16'h2010; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  a_err: assert property (p_err) else $error("error report not gated");
  a_relax: assert property (p_relax) else $error("relaxed attribute wrong");
  a_pass: assert property (p_pass) else $error("forwarded fields changed");
  a_orig: assert property (p_orig) else $error("originated attributes wrong");
  a_fixed: assert property (p_fixed) else $error("fixed bits not zero");
  a_mps: assert property (p_mps) else $error("payload limit wrong");
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule
bind device_control_reg devctl_props props_u (.clk_i, .rst_i, .wb_stb_i, .wb_ack_o,
  .err_event_i, .err_report_o, .fwd_valid_i, .fwd_attr_i, .fwd_valid_o, .fwd_attr_o,
  .orig_valid_i, .orig_valid_o, .orig_attr_o, .payload_limit_o, .device_control_o);
`default_nettype wire

// [dv/testbench.sv]
// testbench: register access, error gating and traffic checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import devctl_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, fv, ov, wb_ack_o, fwd_valid_o, orig_valid_o;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [12:0] ob, payload_limit_o;
  logic [31:0] dat, rd, wb_dat_o;
  err_event_t ev, err_report_o;
  tlp_attr_t fa, fwd_attr_o, orig_attr_o;
  device_control_t device_control_o;
  int failures = 0;
  int comparisons = 0;
  device_control_reg dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .err_event_i(ev),
    .err_report_o, .fwd_valid_i(fv), .fwd_attr_i(fa), .fwd_valid_o, .fwd_attr_o,
    .orig_valid_i(ov), .orig_bytes_i(ob), .orig_valid_o, .orig_attr_o, .payload_limit_o,
    .device_control_o);
  // compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one classic wishbone cycle, read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // one-cycle events and transactions on all traffic inputs
  task automatic pulse(input err_event_t e, input tlp_attr_t a, input logic [12:0] b);
    @(posedge clk_i);
    {ev, fa, ob, fv, ov} <= {e, a, b, 2'b11};
    @(posedge clk_i);
    {ev, fv, ov} <= 6'h00;
    @(negedge clk_i);
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // watchdog
  initial begin
    #50000;
    failures++;
    final_report();
  end
  // test sequence
  initial begin
    {rst_i, cyc, stb, we, fv, ov, adr, sel, ob, dat, ev, fa} = {1'b1, 89'h0};
    sel = 4'hF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 8'h48, 32'h0);
    chk("reset value", rd, 32'h0000_2010);
    chk("reset limit", {19'h0, payload_limit_o}, 32'h0000_0080);
    bus(1'b1, 8'h48, 32'hFFFF_FFFF);
    bus(1'b0, 8'h48, 32'h0);
    chk("all ones", rd, 32'h0000_79FF);
    chk("control view", {16'h0, device_control_o}, 32'h0000_79FF);
    bus(1'b1, 8'h4C, 32'h0);
    bus(1'b0, 8'h4C, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test access done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h48, {24'h0, i[2:0], 5'h0});
      bus(1'b0, 8'h48, 32'h0);
      chk("payload sel", rd, {24'h0, i[2:0], 5'h0});
      chk("payload limit", {19'h0, payload_limit_o}, i > 4 ? 32'h80 : 32'h80 << i);
    end
    $display("test payload done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h48, 32'h1 << i);
      pulse(4'hF, fa, 13'h0);
      chk("error report", {28'h0, err_report_o}, 32'h8 >> i);
    end
    $display("test errors done");
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, 8'h48, 32'h7900 | (r << 4));
      pulse(4'h0, {2'b11, 8'hA5, 13'h1ABC}, r ? 13'h1000 : 13'h0040);
      chk("fwd attr", fwd_attr_o, {r[0], 1'b1, 8'hA5, 13'h1ABC});
      chk("fwd valid", fwd_valid_o, 1);
      chk("orig attr", orig_attr_o, r ? 32'h80 : 32'h40);
      chk("orig valid", orig_valid_o, 1);
    end
    $display("test traffic done");
    final_report();
  end
endmodule
`default_nettype wire
